// file: asram_pkg.sv
// Package of constants and carrier types for the asynchronous SRAM host controller.
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
package asram_pkg;

  localparam int ASRAM_ADDR_W = 14;
  localparam int ASRAM_DATA_W = 4;
  localparam int ASRAM_CLK_PERIOD_NS = 50;
  // Slowest grade figures in nanoseconds.
  localparam int ASRAM_READ_CYCLE_NS = 25;
  localparam int ASRAM_WRITE_PULSE_NS = 15;
  localparam int ASRAM_DATA_SETUP_NS = 10;
  localparam int ASRAM_POWERDOWN_DELAY_NS = 25;
  // Least times round up, none below one cycle.
  localparam int ASRAM_READ_CYCLES = (ASRAM_READ_CYCLE_NS + ASRAM_CLK_PERIOD_NS - 1) / ASRAM_CLK_PERIOD_NS;
  localparam int ASRAM_WRITE_CYCLES = (ASRAM_WRITE_PULSE_NS + ASRAM_CLK_PERIOD_NS - 1) / ASRAM_CLK_PERIOD_NS;
  localparam int ASRAM_SETUP_CYCLES = (ASRAM_DATA_SETUP_NS + ASRAM_CLK_PERIOD_NS - 1) / ASRAM_CLK_PERIOD_NS;
  localparam int ASRAM_CNT_W = 4;
  localparam logic [ASRAM_CNT_W-1:0] ASRAM_CNT_RESET = 4'h0;
  localparam logic [ASRAM_ADDR_W-1:0] ASRAM_ADDR_RESET = 14'h0000;
  localparam logic [ASRAM_DATA_W-1:0] ASRAM_DATA_RESET = 4'h0;

  // Pin group driven toward the memory.
  typedef struct packed {
    logic [ASRAM_ADDR_W-1:0] addr;
    logic [ASRAM_DATA_W-1:0] din;
    logic select_first_n;
    logic select_second_n;
    logic write_n;
  } asram_pins_type;

  // User request.
  typedef struct packed {
    logic valid;
    logic write;
    logic [ASRAM_ADDR_W-1:0] addr;
    logic [ASRAM_DATA_W-1:0] wdata;
  } asram_req_type;

  // User answer.
  typedef struct packed {
    logic ready;
    logic done;
    logic [ASRAM_DATA_W-1:0] rdata;
  } asram_rsp_type;

  typedef enum logic [2:0] {
    ASRAM_IDLE,
    ASRAM_SETUP,
    ASRAM_STROBE,
    ASRAM_RELEASE,
    ASRAM_FINISH
  } asram_state_type;

endpackage : asram_pkg

// file: asram_sync.sv
// Three-stage synchroniser for the read data pins.
`timescale 1ns/100ps
module asram_sync
  import asram_pkg::*;
#(
  parameter int WIDTH = ASRAM_DATA_W
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync,
  output logic o_stable
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
  } asram_sync_state_type;

  asram_sync_state_type state;
  asram_sync_state_type next_state;

  //------------------------------------------------------------
  // Shift chain
  //------------------------------------------------------------
  // The first stage feeds only the second, so metastability never reaches a comparator.
  always_comb begin
    next_state.s1 = i_async;
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // A value counts once the second and third stages agree.
  assign o_sync = state.s3;
  assign o_stable = (state.s2 == state.s3);

endmodule : asram_sync

// file: asram_host.sv
// Host controller that runs reads and writes on an asynchronous 16K x 4 static memory.
`timescale 1ns/100ps
module asram_host
  import asram_pkg::*;
#(
  parameter int READ_CYCLES = ASRAM_READ_CYCLES,
  parameter int WRITE_CYCLES = ASRAM_WRITE_CYCLES,
  parameter int SETUP_CYCLES = ASRAM_SETUP_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire asram_req_type i_req,
  output asram_rsp_type o_rsp,
  output asram_pins_type o_pins,
  input wire logic [ASRAM_DATA_W-1:0] i_dout
);

  //------------------------------------------------------------
  // Elaboration checks
  //------------------------------------------------------------
  // Every state waits at least one clock, so a zero count cannot be served.
  if (READ_CYCLES < 1) begin : g_bad_read_min
    $error("asram_host: read count below one cycle");
  end

  if (WRITE_CYCLES < 1) begin : g_bad_write_min
    $error("asram_host: write count below one cycle");
  end

  if (SETUP_CYCLES < 1) begin : g_bad_setup_min
    $error("asram_host: setup count below one cycle");
  end

  // The counter must hold the longest wait, plus the three synchroniser stages.
  if (READ_CYCLES + 3 >= (1 << ASRAM_CNT_W)) begin : g_bad_read_max
    $error("asram_host: read count too large for the counter");
  end

  if (WRITE_CYCLES >= (1 << ASRAM_CNT_W)) begin : g_bad_write_max
    $error("asram_host: write count too large for the counter");
  end

  if (SETUP_CYCLES >= (1 << ASRAM_CNT_W)) begin : g_bad_setup_max
    $error("asram_host: setup count too large for the counter");
  end

  // Counts shorter than the slowest memory grade would sample or release too early.
  if (READ_CYCLES * ASRAM_CLK_PERIOD_NS < ASRAM_READ_CYCLE_NS) begin : g_short_read
    $error("asram_host: read count shorter than the access time");
  end

  if (WRITE_CYCLES * ASRAM_CLK_PERIOD_NS < ASRAM_WRITE_PULSE_NS) begin : g_short_write
    $error("asram_host: write count shorter than the write pulse");
  end

  if (SETUP_CYCLES * ASRAM_CLK_PERIOD_NS < ASRAM_DATA_SETUP_NS) begin : g_short_setup
    $error("asram_host: setup count shorter than the data setup");
  end

  // The pins must reach every word of a 16384 by 4 array and nothing beyond it.
  if ((1 << ASRAM_ADDR_W) != 16384 || ASRAM_DATA_W != 4) begin : g_bad_geometry
    $error("asram_host: pin widths do not match the memory array");
  end

  // Wait counts as loaded into the counter; a read adds the synchroniser depth.
  localparam logic [ASRAM_CNT_W-1:0] READ_WAIT = ASRAM_CNT_W'(READ_CYCLES + 3);
  localparam logic [ASRAM_CNT_W-1:0] WRITE_WAIT = ASRAM_CNT_W'(WRITE_CYCLES);
  localparam logic [ASRAM_CNT_W-1:0] SETUP_WAIT = ASRAM_CNT_W'(SETUP_CYCLES);

  // All state of the sequencer lives in one record.
  typedef struct packed {
    asram_state_type fsm;
    logic [ASRAM_CNT_W-1:0] cnt;
    logic write;
    asram_pins_type pins;
    asram_rsp_type rsp;
  } asram_host_state_type;

  asram_host_state_type state;
  asram_host_state_type next_state;
  // Synchronised read data and the flag that says its last two stages agree.
  logic [ASRAM_DATA_W-1:0] dout_sync;
  logic dout_stable;

  //------------------------------------------------------------
  // Read data synchroniser
  //------------------------------------------------------------
  asram_sync #(
    .WIDTH(ASRAM_DATA_W)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async(i_dout),
    .o_sync(dout_sync),
    .o_stable(dout_stable)
  );

  //------------------------------------------------------------
  // Access sequencer
  //------------------------------------------------------------
  // Each access walks the same states, one clock or more apiece:
  //   IDLE takes a request and loads address and write data onto the pins.
  //   SETUP waits while the address settles, then lowers both selects together.
  //   STROBE lowers the strobe for a write, or keeps it high while read data ripples
  //   through the memory and the three-stage synchroniser.
  //   RELEASE raises the selects once the strobe is high again, and for a read it
  //   captures the synchronised word when the last two stages agree.
  //   FINISH pulses done and reopens the sequencer for the next request.
  // Address and data are set a full state before any control goes active, and the
  // controls drop a full state before address or data move, so every setup and hold
  // is met with a whole clock of margin at 20 MHz.
  // The strobe rises a full state before the selects, so every write ends on the strobe
  // edge and the selects never end one; this keeps the hold reference in one place.
  // A request that arrives while busy is ignored, not queued, so the user must wait for
  // ready before presenting the next one.
  // A read whose data keeps changing holds the selects low until it settles; a memory
  // that never drives steady data stalls the sequencer, seen as a missing done pulse.
  // Trade-off: whole-clock states waste most of each cycle at 20 MHz, but the logic
  // needs no delay lines and serves every memory grade whose times fit in one clock.
  // Between accesses the pins hold still, so the memory falls back to standby power.
  always_comb begin
    next_state = state;
    next_state.rsp.done = 1'b0;
    case (state.fsm)
      ASRAM_IDLE: begin
        // Ready tells the user that the next request will be taken.
        next_state.rsp.ready = 1'b1;
        if (i_req.valid) begin
          // Address changes only while every control is inactive.
          next_state.pins.addr = i_req.addr;
          next_state.pins.din = i_req.wdata;
          next_state.write = i_req.write;
          next_state.rsp.ready = 1'b0;
          next_state.cnt = SETUP_WAIT;
          next_state.fsm = ASRAM_SETUP;
        end
      end

      ASRAM_SETUP: begin
        // Selects go active only after the address has settled.
        if (state.cnt > 4'h1) begin
          next_state.cnt = state.cnt - 4'h1;
        end else begin
          next_state.pins.select_first_n = 1'b0;
          next_state.pins.select_second_n = 1'b0;
          // The strobe follows the selects, so it is the last control to assert.
          next_state.cnt = state.write ? WRITE_WAIT : READ_WAIT;
          next_state.fsm = ASRAM_STROBE;
        end
      end

      ASRAM_STROBE: begin
        // Strobe falls only for writes; reads keep it high throughout.
        if (state.write) begin
          next_state.pins.write_n = 1'b0;
        end else begin
          next_state.pins.write_n = 1'b1;
        end
        // The first strobe cycle reloads the counter so the pulse lasts the full write count.
        if (state.write && state.pins.write_n) begin
          next_state.cnt = WRITE_WAIT;
        end else if (state.cnt > 4'h1) begin
          next_state.cnt = state.cnt - 4'h1;
        end else begin
          // The strobe ends the write first; selects stay low one more state.
          next_state.pins.write_n = 1'b1;
          next_state.fsm = ASRAM_RELEASE;
        end
      end

      ASRAM_RELEASE: begin
        // The captured word is the synchroniser's third stage.
        if (!state.write) begin
          next_state.rsp.rdata = dout_sync;
        end
        // Read data is loaded every cycle; a write raises the selects at once, a read only once the last two stages agree.
        if (state.write || dout_stable) begin
          next_state.pins.select_first_n = 1'b1;
          next_state.pins.select_second_n = 1'b1;
          next_state.fsm = ASRAM_FINISH;
        end
      end

      ASRAM_FINISH: begin
        // Address and data hold one more state after the controls are gone.
        next_state.rsp.done = 1'b1;
        next_state.rsp.ready = 1'b1;
        next_state.fsm = ASRAM_IDLE;
      end

      // An unknown state falls back to idle; the pins keep whatever values they had.
      default: begin
        next_state.fsm = ASRAM_IDLE;
      end
    endcase
  end

  //------------------------------------------------------------
  // State register
  //------------------------------------------------------------
  // Reset parks every control high, so the memory stays deselected and in standby.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state.fsm <= ASRAM_IDLE;
      state.cnt <= ASRAM_CNT_RESET;
      state.write <= 1'b0;
      state.pins.addr <= ASRAM_ADDR_RESET;
      state.pins.din <= ASRAM_DATA_RESET;
      state.pins.select_first_n <= 1'b1;
      state.pins.select_second_n <= 1'b1;
      state.pins.write_n <= 1'b1;
      state.rsp.ready <= 1'b0;
      state.rsp.done <= 1'b0;
      state.rsp.rdata <= ASRAM_DATA_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Outputs come straight from the state flip-flops.
  assign o_pins = state.pins;
  assign o_rsp = state.rsp;

endmodule : asram_host

// file: asram_checker.sv
// Checker of the host controller's pin sequencing.
`timescale 1ns/100ps
module asram_checker
  import asram_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire asram_req_type i_req,
  input wire asram_rsp_type o_rsp,
  input wire asram_pins_type o_pins,
  input wire logic [ASRAM_DATA_W-1:0] i_dout
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic take;
  // A request is taken on an edge where the controller is idle.
  assign take = o_rsp.ready && i_req.valid;
  a_strobe_in_sel: assert property (!o_pins.write_n |-> !o_pins.select_first_n && !o_pins.select_second_n)
    else $error("strobe low outside selects");
  a_addr_quiet: assert property ($changed(o_pins.addr) |-> o_pins.select_first_n && o_pins.select_second_n)
    else $error("address moved while selected");
  a_addr_first: assert property ($fell(o_pins.select_first_n) |-> $stable(o_pins.addr))
    else $error("address changed with select");
  a_din_held: assert property (!o_pins.write_n |-> $stable(o_pins.din))
    else $error("write data moved under strobe");
  a_read_no_strobe: assert property (take && !i_req.write |=> o_pins.write_n [*7])
    else $error("strobe low in read");
  a_write_strobe: assert property (take && i_req.write |-> ##[2:5] !o_pins.write_n)
    else $error("write strobe missing");
  a_busy_after_take: assert property (take |=> !o_rsp.ready)
    else $error("ready stayed high");
  a_done_pulse: assert property (o_rsp.done |=> !o_rsp.done)
    else $error("done longer than one cycle");
  a_write_done: assert property (take && i_req.write |-> ##[4:8] o_rsp.done)
    else $error("write never completed");
endmodule : asram_checker

bind asram_host asram_checker u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_req(i_req), .o_rsp(o_rsp),
  .o_pins(o_pins), .i_dout(i_dout));

// file: asram_mem_model.sv
// Behavioural model of the 16K x 4 static memory with separate data pins.
`timescale 1ns/100ps
module asram_mem_model
  import asram_pkg::*;
#(
  parameter int ACCESS_NS = 25,
  parameter int POWERDOWN_NS = ASRAM_POWERDOWN_DELAY_NS
) (
  input wire asram_pins_type i_pins,
  output logic [ASRAM_DATA_W-1:0] o_dout,
  output logic o_active_power_state
);
  logic [ASRAM_DATA_W-1:0] mem [16384];
  logic [ASRAM_DATA_W-1:0] junk = 4'h5;
  logic sel;
  logic rd_on;
  realtime stamp = 0;
  initial o_active_power_state = 1'b0;
  assign sel = !i_pins.select_first_n && !i_pins.select_second_n;
  // Data shows only after the access time; floating pins read as a toggling pattern.
  assign #(ACCESS_NS) rd_on = sel && i_pins.write_n;
  assign o_dout = (rd_on && sel && i_pins.write_n) ? mem[i_pins.addr] : junk;
  always #10 junk = ~junk;
  // The array takes data only while all three controls are low.
  always @* if (sel && !i_pins.write_n) mem[i_pins.addr] = i_pins.din;
  task automatic wake();
    stamp = $realtime;
    o_active_power_state = 1'b1;
  endtask : wake
  // Wake events restart the power-down delay, so power follows cycle rate only.
  always @(negedge i_pins.select_first_n or negedge i_pins.select_second_n or negedge i_pins.write_n or i_pins.addr)
    if (sel) wake();
  always @(i_pins.din) if (sel && !i_pins.write_n) wake();
  always #1 if (o_active_power_state && $realtime - stamp >= POWERDOWN_NS) o_active_power_state = 1'b0;
endmodule : asram_mem_model

// file: testbench.sv
// Self-checking bench for the static memory host controller.
`timescale 1ns/100ps
module testbench
  import asram_pkg::*;
();
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  asram_req_type i_req = '0;
  asram_rsp_type o_rsp;
  asram_pins_type o_pins;
  logic [ASRAM_DATA_W-1:0] dout;
  logic [ASRAM_DATA_W-1:0] shadow [16384];
  logic [4:0] expq [$];
  logic [4:0] e;
  logic [31:0] seed = 32'h531d;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  logic pwr;
  logic woke = 1'b0;
  // Remembers that the memory left standby at least once.
  always @(posedge pwr) woke = 1'b1;
  always #25 i_core_clk = ~i_core_clk;
  asram_host uut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_req(i_req), .o_rsp(o_rsp), .o_pins(o_pins),
    .i_dout(dout));
  asram_mem_model u_mem (.i_pins(o_pins), .o_dout(dout), .o_active_power_state(pwr));
  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : next_rand
  task automatic check(input string what, input logic [4:0] exp, input logic [4:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  // One access; while busy a write of inverted data to the same word must be ignored.
  task automatic op(input logic wr, input logic [13:0] a, input logic [3:0] d);
    int n;
    n = 0;
    while (o_rsp.ready !== 1'b1 && n < 40) begin
      @(posedge i_core_clk);
      #2;
      n++;
    end
    i_req = '{1'b1, wr, a, d};
    expq.push_back({wr, wr ? d : shadow[a]});
    if (wr) shadow[a] = d;
    repeat (2) begin
      @(posedge i_core_clk);
      #2;
      i_req = '{1'b1, 1'b1, a, ~d};
    end
    i_req.valid = 1'b0;
  endtask : op
  // Each done pulse retires the oldest expectation; a hang is cut short.
  // Outputs are looked at on the falling edge, half a clock after they settle.
  always @(negedge i_core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end else if (o_rsp.done === 1'b1) begin
      if (expq.size() == 0) begin
        check("spurious done", 5'h00, 5'h1f);
      end else begin
        e = expq.pop_front();
        check(e[4] ? "write data pins" : "read data", e, {e[4], e[4] ? o_pins.din : o_rsp.rdata});
      end
    end
  end
  initial begin
    logic [31:0] r;
    repeat (2) @(posedge i_core_clk);
    #2;
    i_rst = 1'b0;
    op(1'b1, 14'h0000, 4'ha);
    op(1'b1, 14'h3fff, 4'h5);
    op(1'b0, 14'h0000, 4'h0);
    op(1'b0, 14'h3fff, 4'h0);
    $display("test boundary done");
    repeat (12) begin
      r = next_rand();
      op(1'b1, r[13:0], r[17:14]);
      op(1'b0, r[13:0], r[21:18]);
      op(1'b0, r[13:0], r[25:22]);
    end
    $display("test random done");
    while (expq.size() != 0) @(posedge i_core_clk);
    check("idle controls", 5'h07, {2'b00, o_pins.select_first_n, o_pins.select_second_n, o_pins.write_n});
    check("power state", 5'h02, {3'b000, woke, pwr});
    stop_test();
  end
endmodule : testbench
